// ==== rtl/mcu_reset_sequencer.sv ====
// reset sequencer: reset sources, cause flags, start-up hold, reset values
`timescale 1ns/1ps
module mcu_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 5
) (
  input  wire logic                 clock,                // system clock, 10 MHz
  input  wire logic                 rst_n,                // power-on reset, sync, active low
  input  wire logic                 ext_reset_pin_n,      // external reset pin, asynchronous
  input  wire logic                 wdt_overflow,         // watchdog overflow pulse
  input  wire logic                 sleep_instr,          // sleep instruction executed, pulse
  input  wire logic                 watchdog_clear_instr, // watchdog clear instruction, pulse
  input  wire logic                 wake_event,           // other wake-up source, pulse
  input  wire logic                 usb_reset,            // usb bus reset pulse
  output logic                      timeout_flag,         // time-out flag
  output logic                      powerdown_flag,       // power-down flag
  output logic                      asleep,               // device in sleep
  output logic                      cpu_hold,             // execution held
  output logic                      chip_reset,           // full chip reset pulse
  output logic                      warm_reset,           // warm reset pulse
  output logic                      wdt_clear,            // watchdog clear pulse
  output logic [12:0]               pc_value,             // program counter reset value
  output logic [3:0]                sp_value,             // stack pointer reset value
  output logic                      int_enable,           // global interrupt enable state
  output logic                      prescaler_clear,      // prescaler/divider clear pulse
  output logic [7:0]                tmr_ctrl,             // timer control reset state
  output logic [NUM_PORTS*8-1:0]    port_data,            // port data registers
  output logic [NUM_PORTS*8-1:0]    port_dir,             // port direction registers (1 = input)
  output logic [7:0]                scratch_ptr           // pointer register, kept on reset
);
  initial begin
    if (NUM_PORTS < 1 || NUM_PORTS > 8) $error("port count out of range");
  end

  // ***********************************
  // pin synchroniser
  // ***********************************
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;

  // two flops before any use; metastability guard
  // pin synchronised
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_meta_r <= ext_reset_pin_n;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // pin reset acts on the falling edge, once per press
  logic pin_fall;
  assign pin_fall = pin_prev_r & ~pin_sync_r;

  // ***********************************
  // state and cause decode
  // ***********************************
  seq_state_e  state_r;
  seq_state_e  state_nxt;
  reset_kind_e kind;
  logic        hold_start;
  logic        hold_busy;

  // classify the event; pin outranks watchdog
  // reset sources
  always_comb begin
    kind = RK_NONE;
    if (state_r == ST_RUN || state_r == ST_SLEEP) begin
      if (pin_fall) begin
        kind = RK_PIN;
      end else if (wdt_overflow) begin
        kind = (state_r == ST_SLEEP) ? RK_WARM : RK_WDT;
      end else if (usb_reset) begin
        kind = RK_USB;
      end
    end
  end

  // wake-ups start a fresh hold
  assign hold_start = (state_r == ST_SLEEP) && (kind != RK_NONE || wake_event);

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_POWERUP: begin
        if (!hold_busy) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (kind == RK_NONE && sleep_instr) state_nxt = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (hold_start) state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (!hold_busy && !hold_start) state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= ST_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  startup_delay_timer #(
    .COUNT (STARTUP_CYCLES),
    .W     (STARTUP_W)
  ) u_hold (
    .clock (clock),
    .rst_n (rst_n),
    .start (hold_start),
    .busy  (hold_busy)
  );

  assign asleep   = (state_r == ST_SLEEP);
  assign cpu_hold = (state_r != ST_RUN);

  // ***********************************
  // cause flags
  // ***********************************
  logic to_r;
  logic to_nxt;
  logic pd_r;
  logic pd_nxt;

  // reset causes take priority over instructions in the same cycle
  always_comb begin
    to_nxt = to_r;
    pd_nxt = pd_r;
    unique case (kind)
      RK_PIN: begin
        if (state_r == ST_SLEEP) begin
          to_nxt = FLAG_CLEAR;
          pd_nxt = FLAG_SET;
        end
      end
      RK_WDT: to_nxt = FLAG_SET;
      RK_WARM: begin
        to_nxt = FLAG_SET;
        pd_nxt = FLAG_SET;
      end
      RK_USB: ;
      RK_NONE: begin
        if (state_r == ST_RUN && sleep_instr) begin
          to_nxt = FLAG_CLEAR;
          pd_nxt = FLAG_SET;
        end else if (state_r == ST_RUN && watchdog_clear_instr) begin
          to_nxt = FLAG_CLEAR;
          pd_nxt = FLAG_CLEAR;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      to_r <= FLAG_CLEAR;
      pd_r <= FLAG_CLEAR;
    end else begin
      to_r <= to_nxt;
      pd_r <= pd_nxt;
    end
  end

  assign timeout_flag   = to_r;
  assign powerdown_flag = pd_r;

  // ***********************************
  // reset pulses and register values
  // ***********************************
  logic                   chip_nxt;
  logic                   chip_r;
  logic                   warm_nxt;
  logic                   warm_r;
  logic                   wclr_nxt;
  logic                   wclr_r;
  logic                   ie_r;
  logic                   ie_nxt;
  logic [7:0]             tmr_r;
  logic [7:0]             tmr_nxt;
  logic [NUM_PORTS*8-1:0] pdat_r;
  logic [NUM_PORTS*8-1:0] pdat_nxt;
  logic [NUM_PORTS*8-1:0] pdir_r;
  logic [NUM_PORTS*8-1:0] pdir_nxt;
  logic [7:0]             ptr_r;

  // pin, normal watchdog and usb are full resets; warm is not
  assign chip_nxt = (kind == RK_PIN) || (kind == RK_WDT) || (kind == RK_USB);
  assign warm_nxt = (kind == RK_WARM);
  assign wclr_nxt = chip_nxt || warm_nxt || watchdog_clear_instr;

  // reset values of functional units
  always_comb begin
    ie_nxt   = ie_r;
    tmr_nxt  = tmr_r;
    pdat_nxt = pdat_r;
    pdir_nxt = pdir_r;
    if (chip_nxt) begin
      ie_nxt  = 1'b0;
      tmr_nxt = TMRC_RESET;
      pdat_nxt = {NUM_PORTS{PORT_RESET}};
      pdir_nxt = {NUM_PORTS{PORT_RESET}};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chip_r <= 1'b1;
      warm_r <= 1'b0;
      wclr_r <= 1'b1;
      ie_r   <= 1'b0;
      tmr_r  <= TMRC_RESET;
      pdat_r <= {NUM_PORTS{PORT_RESET}};
      pdir_r <= {NUM_PORTS{PORT_RESET}};
    end else begin
      chip_r <= chip_nxt;
      warm_r <= warm_nxt;
      wclr_r <= wclr_nxt;
      ie_r   <= ie_nxt;
      tmr_r  <= tmr_nxt;
      pdat_r <= pdat_nxt;
      pdir_r <= pdir_nxt;
    end
  end

  always_ff @(posedge clock) begin
    ptr_r <= ptr_r;
  end

  assign chip_reset      = chip_r;
  assign warm_reset      = warm_r;
  assign wdt_clear       = wclr_r;
  assign prescaler_clear = chip_r;
  assign pc_value        = PC_RESET;
  assign sp_value        = SP_RESET;
  assign int_enable      = ie_r;
  assign tmr_ctrl        = tmr_r;
  assign port_data       = pdat_r;
  assign port_dir        = pdir_r;
  assign scratch_ptr     = ptr_r;

  // ***********************************
  // checks
  // ***********************************
  pin_wake_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_SLEEP && pin_fall) |=> (!timeout_flag && powerdown_flag))
    else $error("pin wake-up flags wrong");
  wdt_wake_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_SLEEP && !pin_fall && wdt_overflow) |=> (timeout_flag && powerdown_flag && warm_reset))
    else $error("watchdog wake-up flags wrong");
  wdt_run_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_RUN && !pin_fall && wdt_overflow) |=> (timeout_flag && $stable(powerdown_flag) && chip_reset))
    else $error("watchdog run reset wrong");
  pin_run_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_RUN && pin_fall) |=> ($stable(timeout_flag) && $stable(powerdown_flag) && chip_reset))
    else $error("pin reset changed flags");
  warm_keeps_ports_a: assert property (@(posedge clock) disable iff (!rst_n)
    warm_reset |-> (!chip_reset && $stable(port_data) && $stable(port_dir)))
    else $error("warm reset touched ports");
  chip_ports_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_reset |-> (port_dir == {NUM_PORTS{PORT_RESET}} && !int_enable && tmr_ctrl == TMRC_RESET))
    else $error("chip reset values wrong");
  wake_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_SLEEP && hold_start) |=> cpu_hold [*8])
    else $error("wake without hold");
  sleep_pd_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == ST_RUN && kind == RK_NONE && sleep_instr) |=> (powerdown_flag && asleep))
    else $error("sleep did not set power-down");
  reset_clears_wdt_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_reset |-> wdt_clear)
    else $error("chip reset left watchdog");

  cov_pin_wake: cover property (@(posedge clock) state_r == ST_SLEEP && pin_fall);
  cov_warm: cover property (@(posedge clock) warm_reset);
  cov_wdt_run: cover property (@(posedge clock) state_r == ST_RUN && wdt_overflow);
  cov_hold_end: cover property (@(posedge clock) $fell(cpu_hold));
endmodule // mcu_reset_sequencer

// ==== rtl/rst_seq_pkg.sv ====
// package: constants and types for the reset sequencer
package rst_seq_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned STARTUP_CYCLES    = 1024;        // system clock periods of start-up hold
  localparam int unsigned STARTUP_W         = 11;
  localparam logic [12:0] PC_RESET          = 13'h0000;    // program counter after reset
  localparam logic [3:0]  SP_RESET          = 4'h0;        // stack pointer at stack top
  localparam logic [7:0]  PORT_RESET        = 8'hFF;       // port data/direction after reset
  localparam logic [7:0]  TMRC_RESET        = 8'h08;       // timer control: timer off
  localparam logic        FLAG_CLEAR        = 1'b0;
  localparam logic        FLAG_SET          = 1'b1;

  // reset kinds
  typedef enum logic [4:0] {
    RK_NONE = 5'h01,
    RK_PIN  = 5'h02,
    RK_WDT  = 5'h04,
    RK_WARM = 5'h08,
    RK_USB  = 5'h10
  } reset_kind_e;

  // sequencer states
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_RUN     = 4'h2,
    ST_SLEEP   = 4'h4,
    ST_HOLD    = 4'h8
  } seq_state_e;
endpackage

// ==== rtl/startup_delay_timer.sv ====
// start-up hold counter
`timescale 1ns/1ps
module startup_delay_timer #(
  parameter int unsigned COUNT = 1024,
  parameter int unsigned W     = 11
) (
  input  wire logic clock,          // system clock
  input  wire logic rst_n,          // sync reset, active low
  input  wire logic start,          // load the count
  output logic      busy            // hold active
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  initial begin
    if (COUNT < 1 || COUNT >= (1 << W)) $error("startup count does not fit");
  end

  // count down from COUNT, busy while nonzero
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = W'(COUNT);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // power-up also runs the hold
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= W'(COUNT);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != '0);

  // ***********************************
  // checks
  // ***********************************
  hold_length_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(busy) |-> busy [*8]) else $error("hold shorter than expected");
endmodule // startup_delay_timer

// ==== test/reset_partner.sv ====
// partner model: external reset pin and on-chip watchdog
`timescale 1ns/1ps
module reset_partner (
  input  wire logic clock,           // system clock
  output logic      ext_reset_pin_n, // reset pin, pulled high when released
  output logic      wdt_overflow     // watchdog overflow pulse
);
  // idle: pin released to its pull-up, watchdog quiet
  initial begin
    ext_reset_pin_n = 1'b1;
    wdt_overflow    = 1'b0;
  end

  // pin press
  // pin moves off the clock grid on purpose, so only the synchroniser makes it safe
  task automatic press(input int len);
    @(negedge clock);
    #13 ext_reset_pin_n = 1'b0;
    repeat (len) @(negedge clock);
    #13 ext_reset_pin_n = 1'b1;
  endtask

  task automatic bite();
    @(negedge clock);
    wdt_overflow = 1'b1;
    @(negedge clock);
    wdt_overflow = 1'b0;
  endtask
endmodule // reset_partner

// ==== test/mcu_reset_sequencer_tb.sv ====
// testbench for the reset sequencer
`timescale 1ns/1ps
module mcu_reset_sequencer_tb;
  import rst_seq_pkg::*;
  localparam int NP = 5;
  logic clock, rst_n, sleep_instr, watchdog_clear_instr, wake_event, usb_reset;
  wire  ext_reset_pin_n, wdt_overflow;
  logic timeout_flag, powerdown_flag, asleep, cpu_hold, chip_reset, warm_reset, wdt_clear;
  logic int_enable, prescaler_clear;
  logic [12:0]     pc_value;
  logic [3:0]      sp_value;
  logic [7:0]      tmr_ctrl, scratch_ptr;
  logic [NP*8-1:0] port_data, port_dir;
  int              miscompares, cmp_count, n;
  bit              seen_chip, seen_warm;

  reset_partner partner (.clock(clock), .ext_reset_pin_n(ext_reset_pin_n), .wdt_overflow(wdt_overflow));
  mcu_reset_sequencer #(.NUM_PORTS(NP)) uut (
    .clock(clock), .rst_n(rst_n), .ext_reset_pin_n(ext_reset_pin_n), .wdt_overflow(wdt_overflow),
    .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr), .wake_event(wake_event),
    .usb_reset(usb_reset), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .asleep(asleep),
    .cpu_hold(cpu_hold), .chip_reset(chip_reset), .warm_reset(warm_reset), .wdt_clear(wdt_clear),
    .pc_value(pc_value), .sp_value(sp_value), .int_enable(int_enable), .prescaler_clear(prescaler_clear),
    .tmr_ctrl(tmr_ctrl), .port_data(port_data), .port_dir(port_dir), .scratch_ptr(scratch_ptr));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic flags(input logic to, input logic pd);
    chk("timeout_flag", {39'h0, to}, {39'h0, timeout_flag});
    chk("powerdown_flag", {39'h0, pd}, {39'h0, powerdown_flag});
  endtask
  // values loaded with every full reset pulse
  task automatic rvals();
    chk("pc_value", PC_RESET, pc_value);
    chk("sp_value", SP_RESET, sp_value);
    chk("int_enable", 40'h0, int_enable);
    chk("prescaler_clear", 40'h1, prescaler_clear);
    chk("tmr_ctrl", TMRC_RESET, tmr_ctrl);
    chk("wdt_clear", 40'h1, wdt_clear);
    chk("port_data", {NP{PORT_RESET}}, port_data);
    chk("port_dir", {NP{PORT_RESET}}, port_dir);
  endtask
  // one-cycle pulse on a bench-owned input
  task automatic drive(input int which);
    @(negedge clock);
    case (which)
      0: sleep_instr = 1'b1;
      1: watchdog_clear_instr = 1'b1;
      2: wake_event = 1'b1;
      default: usb_reset = 1'b1;
    endcase
    @(negedge clock);
    {sleep_instr, watchdog_clear_instr, wake_event, usb_reset} = 4'h0;
  endtask
  // bounded wait for either reset pulse; outputs read once settled
  task automatic wait_rst();
    seen_chip = 0;
    seen_warm = 0;
    repeat (20) begin
      @(posedge clock);
      #1;
      if (chip_reset === 1'b1 || warm_reset === 1'b1) begin
        seen_chip = chip_reset;
        seen_warm = warm_reset;
        break;
      end
    end
  endtask
  // hold length with a little slack for the pulse cycle itself
  task automatic hold_len();
    n = 0;
    while (cpu_hold === 1'b1 && n < 1100) begin
      @(posedge clock);
      #1 n++;
    end
    chk("hold_cycles", 40'h1, (n >= STARTUP_CYCLES - 2 && n <= STARTUP_CYCLES + 3));
  endtask
  task automatic rst_seen(input bit c, input bit w);
    chk("chip_reset", c, seen_chip);
    chk("warm_reset", w, seen_warm);
  endtask
  task automatic go_sleep();
    fork drive(0); begin @(posedge clock); #1; end join
    chk("asleep", 40'h1, asleep);
    flags(1'b0, 1'b1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_wdt_run();
    fork partner.bite(); wait_rst(); join
    rst_seen(1, 0);
    flags(1'b1, 1'b0);
    rvals();
    @(posedge clock);
    #1 chk("chip_reset_len", 40'h0, chip_reset);
    chk("cpu_hold", 40'h0, cpu_hold);
  endtask
  // the press outlasts the one-cycle pulse, so judge it while it stands
  task automatic t_pin_run();
    fork
      partner.press(6);
      begin
        wait_rst();
        rst_seen(1, 0);
        flags(1'b1, 1'b0);
        rvals();
      end
    join
  endtask
  task automatic t_usb();
    fork drive(3); wait_rst(); join
    rst_seen(1, 0);
    flags(1'b1, 1'b0);
  endtask
  task automatic t_clear();
    drive(1);
    chk("wdt_clear", 40'h1, wdt_clear);
    flags(1'b0, 1'b0);
  endtask
  task automatic t_pin_sleep();
    go_sleep();
    fork partner.press(2); wait_rst(); join
    rst_seen(1, 0);
    flags(1'b0, 1'b1);
    rvals();
    hold_len();
  endtask
  task automatic t_wdt_sleep();
    go_sleep();
    fork partner.bite(); wait_rst(); join
    rst_seen(0, 1);
    flags(1'b1, 1'b1);
    chk("pc_value", PC_RESET, pc_value);
    chk("port_data", {NP{PORT_RESET}}, port_data);
    hold_len();
  endtask
  task automatic t_wake();
    go_sleep();
    drive(2);
    hold_len();
    chk("asleep", 40'h0, asleep);
    flags(1'b0, 1'b1);
  endtask
  task automatic t_reset(input int len);
    @(negedge clock);
    rst_n = 1'b0;
    repeat (len) @(negedge clock);
    chk("chip_reset", 40'h1, chip_reset);
    flags(1'b0, 1'b0);
    rvals();
    rst_n = 1'b1;
    hold_len();
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // free-running system clock, 100 ns
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // main sequence; second power-on reset arrives with only the power-down flag set
  initial begin
    {rst_n, sleep_instr, watchdog_clear_instr, wake_event, usb_reset} = 5'h0;
    miscompares = 0;
    cmp_count = 0;
    t_reset(4);
    t_wdt_run();
    t_pin_run();
    t_usb();
    t_clear();
    t_pin_sleep();
    t_wdt_sleep();
    t_wake();
    t_reset(4);
    end_of_test();
  end
  // a hang costs a mismatch; the run needs about 5200 cycles
  initial begin
    #1_500_000;
    miscompares++;
    end_of_test();
  end
endmodule // mcu_reset_sequencer_tb
